// [rtl/pcs_card_host.sv]
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/100ps
module pcs_card_host
  import pcs_pkg::*;
(
  input logic aclk,
  input logic aresetn,
  pcs_card_if.host link,
  input logic [7:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  output logic s_axi_awready,
  input logic [31:0] s_axi_wdata,
  input logic [3:0] s_axi_wstrb,
  input logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic [7:0] s_axi_araddr,
  input logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input logic s_axi_rready
);
  typedef struct packed {
    pcs_host_state_t st;
    logic [5:0] cnt;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [2:0] cmd;
    logic [15:0] rdata;
    logic [15:0] window;
    logic card_reset;
    logic done;
    logic miss;
    logic aw_ok;
    logic w_ok;
    logic [7:0] awaddr;
    logic [31:0] axi_w;
    logic [3:0] strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] axi_r;
    logic [1:0] rresp;
    logic ce_n;
    logic strobe;
  } pcs_host_t;

  pcs_host_t s;
  pcs_host_t next_s;
  logic is_io;
  logic is_wr;

  function automatic logic [15:0] merge16(input logic [15:0] old,
    input logic [31:0] val, input logic [3:0] strb);
    merge16 = {strb[1] ? val[15:8] : old[15:8],
      strb[0] ? val[7:0] : old[7:0]};
  endfunction : merge16

  function automatic logic [31:0] status_word(input pcs_host_t h);
    status_word = 32'h00000000;
    status_word[ST_BUSY_BIT] = h.st != HST_IDLE;
    status_word[ST_DONE_BIT] = h.done;
    status_word[ST_MISS_BIT] = h.miss;
  endfunction : status_word

  assign is_io = s.cmd[1];
  assign is_wr = s.cmd[0];

  always_comb
  begin
    next_s = s;
    if (s_axi_awvalid && !s.aw_ok)
    begin
      next_s.aw_ok = 1'b1;
      next_s.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s.w_ok)
    begin
      next_s.w_ok = 1'b1;
      next_s.axi_w = s_axi_wdata;
      next_s.strb = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready)
      next_s.bvalid = 1'b0;
    if (s.rvalid && s_axi_rready)
      next_s.rvalid = 1'b0;
    if (s_axi_arvalid && !s.rvalid)
    begin
      next_s.rvalid = 1'b1;
      next_s.rresp = AXI_OKAY;
      unique case (s_axi_araddr)
        HOST_ADDR_OFFSET: next_s.axi_r = {16'h0000, s.addr};
        HOST_WDATA_OFFSET: next_s.axi_r = {16'h0000, s.wdata};
        HOST_CMD_OFFSET: next_s.axi_r = {29'h00000000, s.cmd};
        HOST_RDATA_OFFSET: next_s.axi_r = {16'h0000, s.rdata};
        HOST_STATUS_OFFSET: next_s.axi_r = status_word(s);
        HOST_WINDOW_OFFSET: next_s.axi_r = {16'h0000, s.window};
        HOST_CTRL_OFFSET: next_s.axi_r = {31'h00000000, s.card_reset};
        default:
        begin
          next_s.axi_r = 32'h00000000;
          next_s.rresp = AXI_SLVERR;
        end
      endcase
    end
    if (s.aw_ok && s.w_ok && !s.bvalid)
    begin
      next_s.aw_ok = 1'b0;
      next_s.w_ok = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = AXI_OKAY;
      unique case (s.awaddr)
        HOST_ADDR_OFFSET: next_s.addr = merge16(s.addr, s.axi_w, s.strb);
        HOST_WDATA_OFFSET:
          next_s.wdata = merge16(s.wdata, s.axi_w, s.strb);
        HOST_CMD_OFFSET:
        begin
          // Ignored while a card cycle is still running
          if (s.st == HST_IDLE && s.strb[0])
          begin
            next_s.cmd = s.axi_w[2:0];
            next_s.done = 1'b0;
            next_s.miss = 1'b0;
            next_s.cnt = 6'h00;
            next_s.st = HST_SETUP;
            // I/O commands outside the window get no card select at all
            if (s.axi_w[1] && s.addr[15:6] != s.window[15:6])
            begin
              next_s.st = HST_IDLE;
              next_s.miss = 1'b1;
              next_s.done = 1'b1;
            end
            else
              next_s.ce_n = 1'b0;
          end
        end
        HOST_STATUS_OFFSET:
        begin
          if (s.strb[0] && s.axi_w[ST_DONE_BIT])
            next_s.done = 1'b0;
          if (s.strb[0] && s.axi_w[ST_MISS_BIT])
            next_s.miss = 1'b0;
        end
        HOST_WINDOW_OFFSET:
          next_s.window = merge16(s.window, s.axi_w, s.strb);
        HOST_CTRL_OFFSET:
          if (s.strb[0])
            next_s.card_reset = s.axi_w[0];
        default:
          next_s.bresp = AXI_SLVERR;
      endcase
    end
    unique case (s.st)
      HST_IDLE:
        next_s.strobe = 1'b0;
      HST_SETUP:
      begin
        next_s.cnt = s.cnt + 6'h01;
        if (s.cnt == 6'(SETUP_CYCLES - 1))
        begin
          next_s.st = HST_STROBE;
          next_s.strobe = 1'b1;
          next_s.cnt = 6'h00;
        end
      end
      HST_STROBE:
      begin
        if (s.cnt != 6'(STROBE_CYCLES - 1))
          next_s.cnt = s.cnt + 6'h01;
        else if (link.wait_n)
        begin
          next_s.st = HST_RECOVER;
          next_s.strobe = 1'b0;
          next_s.rdata = link.d;
          next_s.cnt = 6'h00;
        end
      end
      HST_RECOVER:
      begin
        next_s.cnt = s.cnt + 6'h01;
        if (s.cnt == 6'(HOLD_CYCLES - 1))
        begin
          next_s.st = HST_IDLE;
          next_s.ce_n = 1'b1;
          next_s.done = 1'b1; // Set wins over a same-cycle clear
        end
      end
      default:
        next_s.st = HST_IDLE;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s <= '0;
      s.st <= HST_IDLE;
      s.ce_n <= 1'b1;
    end
    else
      s <= next_s;
  end

  assign s_axi_awready = !s.aw_ok;
  assign s_axi_wready = !s.w_ok;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = !s.rvalid;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.axi_r;
  assign s_axi_rresp = s.rresp;
  assign link.addr = s.addr;
  assign link.host_d = s.wdata;
  assign link.host_d_oe = is_wr && s.st != HST_IDLE;
  assign link.ce1_n = s.ce_n;
  assign link.ce2_n = s.ce_n || !is_io;
  assign link.reg_n = s.ce_n || !(is_io || s.cmd[CMD_ATTR_BIT]);
  assign link.oe_n = !(s.strobe && !is_io && !is_wr);
  assign link.we_n = !(s.strobe && !is_io && is_wr);
  assign link.iord_n = !(s.strobe && is_io && !is_wr);
  assign link.iowr_n = !(s.strobe && is_io && is_wr);
  assign link.card_reset = s.card_reset;
endmodule : pcs_card_host

// [rtl/pcs_pkg.sv]
package pcs_pkg;
  localparam int CLK_PERIOD_NS = 4;
  localparam int EXT_ACCESS_NS = 100;
  localparam int HOST_SETUP_NS = 30;
  localparam int HOST_STROBE_NS = 150;
  localparam int HOST_HOLD_NS = 20;
  localparam int EXT_CYCLES = (EXT_ACCESS_NS + CLK_PERIOD_NS - 1)
    / CLK_PERIOD_NS;
  localparam int SETUP_CYCLES = (HOST_SETUP_NS + CLK_PERIOD_NS - 1)
    / CLK_PERIOD_NS;
  localparam int STROBE_CYCLES = (HOST_STROBE_NS + CLK_PERIOD_NS - 1)
    / CLK_PERIOD_NS;
  localparam int HOLD_CYCLES = (HOST_HOLD_NS + CLK_PERIOD_NS - 1)
    / CLK_PERIOD_NS;
  localparam logic [15:0] CFG_OPTION_OFFSET = 16'h03F0;
  localparam logic [15:0] CFG_SECOND_OFFSET = 16'h03F2;
  localparam logic [15:0] CFG_THIRD_OFFSET = 16'h03F4;
  localparam logic [15:0] CFG_FOURTH_OFFSET = 16'h03F6;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam int CFG_IO_ENABLE_BIT = 0;
  localparam int CFG_INDEX_MSB = 5;
  localparam int PROG_IO_SELECT_BIT = 13;
  localparam int NONVOL_WRITE_ENABLE_BIT = 8;
  localparam int IO_SEL_BITS = 5;
  localparam logic [7:0] HOST_ADDR_OFFSET = 8'h00;
  localparam logic [7:0] HOST_WDATA_OFFSET = 8'h04;
  localparam logic [7:0] HOST_CMD_OFFSET = 8'h08;
  localparam logic [7:0] HOST_RDATA_OFFSET = 8'h0C;
  localparam logic [7:0] HOST_STATUS_OFFSET = 8'h10;
  localparam logic [7:0] HOST_WINDOW_OFFSET = 8'h14;
  localparam logic [7:0] HOST_CTRL_OFFSET = 8'h18;
  localparam logic [1:0] OP_MEM_RD = 2'h0;
  localparam logic [1:0] OP_MEM_WR = 2'h1;
  localparam logic [1:0] OP_IO_RD = 2'h2;
  localparam logic [1:0] OP_IO_WR = 2'h3;
  localparam int CMD_ATTR_BIT = 2;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_DONE_BIT = 1;
  localparam int ST_MISS_BIT = 2;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    DEV_IDLE = 3'b001,
    DEV_ACCESS = 3'b010,
    DEV_HOLD = 3'b100
  } pcs_dev_state_t;

  typedef enum logic [3:0] {
    HST_IDLE = 4'b0001,
    HST_SETUP = 4'b0010,
    HST_STROBE = 4'b0100,
    HST_RECOVER = 4'b1000
  } pcs_host_state_t;

  function automatic logic pcs_cfg_hit(input logic [15:0] a);
    pcs_cfg_hit = (a[15:3] == CFG_OPTION_OFFSET[15:3]) && !a[0];
  endfunction : pcs_cfg_hit
endpackage : pcs_pkg

// [rtl/pcs_card_if.sv]
`timescale 1ns/100ps
interface pcs_card_if;
  logic [15:0] addr;
  logic [15:0] host_d;
  logic host_d_oe;
  logic ce1_n;
  logic ce2_n;
  logic reg_n;
  logic oe_n;
  logic we_n;
  logic iord_n;
  logic iowr_n;
  logic card_reset;
  logic [15:0] card_d;
  logic card_d_oe;
  logic wait_val_n;
  logic wait_oe;
  logic iois16_val_n;
  logic iois16_oe;
  logic inpack_n;
  logic ireq_n;
  logic stschg_n;
  logic [15:0] d;
  logic wait_n;
  logic iois16_n;

  // Idle data sits low on its pull-downs; WAIT and IOIS16 idle high
  assign d = card_d_oe ? card_d : (host_d_oe ? host_d : 16'h0000);
  assign wait_n = wait_oe ? wait_val_n : 1'b1;
  assign iois16_n = iois16_oe ? iois16_val_n : 1'b1;

  modport device (
    input addr, d, ce1_n, ce2_n, reg_n, oe_n, we_n, iord_n, iowr_n,
    input card_reset,
    output card_d, card_d_oe, wait_val_n, wait_oe, iois16_val_n,
    output iois16_oe, inpack_n, ireq_n, stschg_n
  );
  modport host (
    output addr, host_d, host_d_oe, ce1_n, ce2_n, reg_n, oe_n, we_n,
    output iord_n, iowr_n, card_reset,
    input d, wait_n, iois16_n, inpack_n, ireq_n, stschg_n
  );
endinterface : pcs_card_if

// [rtl/pcs_cfg_regs.sv]
`timescale 1ns/100ps
module pcs_cfg_regs
  import pcs_pkg::*;
(
  input logic aclk,
  input logic aresetn,
  input logic clear,
  input logic wr,
  input logic [1:0] idx,
  input logic [7:0] wdata,
  output logic [7:0] rdata,
  output logic [CFG_INDEX_MSB:0] config_index,
  output logic io_enable
);
  typedef struct packed {
    logic [3:0][7:0] r;
  } pcs_cfg_t;

  pcs_cfg_t s;
  pcs_cfg_t next_s;

  always_comb
  begin
    next_s = s;
    if (clear)
      next_s.r = {4{CFG_RESET}};
    else if (wr)
      next_s.r[idx] = wdata;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s.r <= {4{CFG_RESET}};
    else
      s <= next_s;
  end

  assign rdata = s.r[idx];
  assign config_index = s.r[0][CFG_INDEX_MSB:0];
  assign io_enable = s.r[0][CFG_IO_ENABLE_BIT];
endmodule : pcs_cfg_regs

// [rtl/pcs_card_device.sv]
`timescale 1ns/100ps
// How it works
// - Card mode strap remaps slave pins to card
// - WAIT and IOIS16 push-pull in card mode
// - No I/O response until host configures
// - REG selects attribute or common space
// - Attribute space answers even addresses only
// - Four config registers at 1008 to 1014
// - I/O answered only while enable bit set
// - First register holds configuration index field
// - I/O register select from five address bits
// - Host decodes upper I/O bits before CE
// - One external flash holds CIS and drivers
// - Attribute address zero is flash byte zero
// - REG deasserted means common memory access
// - Common access with match high hits flash
// - Match low in shared mode hits RAM
// - Board may tie match high for PIO
// - Flash reads always allowed
// - Flash writes need nonvolatile write enable
// - Station address belongs in CIS, EEPROM optional
// - Sleep input keeps its function
// - Programmed-I/O select bit chooses architecture
module pcs_card_device
  import pcs_pkg::*;
(
  input logic aclk,
  input logic aresetn,
  pcs_card_if.device link,
  input logic card_mode_strap,
  input logic shared_mem_match,
  input logic sleep_n,
  input logic [15:0] misc_config_reg_two,
  input logic core_irq,
  input logic core_status_change,
  output logic core_sleep,
  output logic [15:0] ext_addr,
  output logic [15:0] ext_wdata,
  output logic ext_rd,
  output logic ext_wr,
  output logic flash_sel,
  output logic local_ram_select,
  output logic io_access,
  output logic [IO_SEL_BITS-1:0] io_sel,
  input logic [7:0] flash_rdata,
  input logic [15:0] ram_rdata,
  input logic [15:0] io_rdata,
  output logic [CFG_INDEX_MSB:0] config_index
);
  typedef struct packed {
    pcs_dev_state_t st;
    logic [5:0] cnt;
    logic wr;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic rd_en;
    logic wr_en;
    logic flash;
    logic ram;
    logic io;
    logic [15:0] rdata;
    logic d_oe;
    logic wait_n;
    logic iois16;
    logic inpack;
    logic ireq;
    logic stschg;
    logic sleep;
  } pcs_dev_t;

  pcs_dev_t s;
  pcs_dev_t next_s;
  logic mem_rd;
  logic mem_wr;
  logic io_rd;
  logic io_wr;
  logic ce;
  logic attr;
  logic io_enable;
  logic prog_io_select;
  logic nonvol_write_enable;
  logic want_io;
  logic want_mem;
  logic want_cfg;
  logic want_flash;
  logic want_ram;
  logic cfg_wr;
  logic [7:0] cfg_rdata;

  function automatic pcs_dev_t dev_reset();
    pcs_dev_t r;
    r = '0;
    r.st = DEV_IDLE;
    r.wait_n = 1'b1;
    dev_reset = r;
  endfunction : dev_reset

  // Card strobes replace the slave-mode pins only under the strap
  assign mem_rd = card_mode_strap && !link.oe_n;
  assign mem_wr = card_mode_strap && !link.we_n;
  assign io_rd = card_mode_strap && !link.iord_n;
  assign io_wr = card_mode_strap && !link.iowr_n;
  assign ce = !link.ce1_n || !link.ce2_n;
  assign attr = !link.reg_n;
  assign prog_io_select = misc_config_reg_two[PROG_IO_SELECT_BIT];
  assign nonvol_write_enable =
    misc_config_reg_two[NONVOL_WRITE_ENABLE_BIT];

  // Before configuration io_enable is clear: memory-only card
  assign want_io = ce && (io_rd || io_wr) && attr
    && io_enable;
  assign want_mem = ce && (mem_rd || mem_wr);
  assign want_cfg = want_mem && attr && pcs_cfg_hit(link.addr);
  // Odd attribute bytes get no answer at all
  assign want_flash = want_mem && !want_cfg
    && (attr ? !link.addr[0]
    : shared_mem_match);
  assign want_ram = want_mem && !attr && !shared_mem_match
    && !prog_io_select;
  assign cfg_wr = (s.st == DEV_IDLE) && want_cfg && mem_wr;

  pcs_cfg_regs u_cfg (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(link.card_reset),
    .wr(cfg_wr),
    .idx(link.addr[2:1]),
    .wdata(link.d[7:0]),
    .rdata(cfg_rdata),
    .config_index(config_index),
    .io_enable(io_enable)
  );

  always_comb
  begin
    next_s = s;
    next_s.ireq = card_mode_strap && io_enable && core_irq;
    next_s.stschg = card_mode_strap && io_enable && core_status_change;
    next_s.sleep = !sleep_n;
    unique case (s.st)
      DEV_IDLE:
      begin
        next_s.d_oe = 1'b0;
        next_s.inpack = 1'b0;
        next_s.iois16 = 1'b0;
        next_s.wait_n = 1'b1;
        next_s.wr = mem_wr || io_wr;
        next_s.wdata = link.d;
        next_s.addr = link.addr;
        if (want_io || want_flash || want_ram)
        begin
          next_s.st = DEV_ACCESS;
          next_s.cnt = 6'h00;
          next_s.wait_n = 1'b0;
          next_s.io = want_io;
          next_s.flash = want_flash;
          next_s.ram = want_ram;
          next_s.rd_en = !(mem_wr || io_wr);
          // Blocked flash writes still finish the bus cycle
          next_s.wr_en = (mem_wr || io_wr)
            && (!want_flash || nonvol_write_enable);
          next_s.iois16 = want_io;
          next_s.inpack = want_io && io_rd;
          if (want_io)
            next_s.addr = {11'h000, link.addr[IO_SEL_BITS-1:0]};
        end
        else if (want_cfg)
        begin
          next_s.st = DEV_HOLD;
          next_s.rdata = {8'h00, cfg_rdata};
          next_s.d_oe = mem_rd;
        end
      end
      DEV_ACCESS:
      begin
        next_s.cnt = s.cnt + 6'h01;
        if (s.cnt == 6'(EXT_CYCLES - 1))
        begin
          next_s.st = DEV_HOLD;
          next_s.rd_en = 1'b0;
          next_s.wr_en = 1'b0;
          next_s.flash = 1'b0;
          next_s.ram = 1'b0;
          next_s.io = 1'b0;
          next_s.wait_n = 1'b1;
          next_s.d_oe = !s.wr;
          if (s.flash)
            next_s.rdata = {8'h00, flash_rdata};
          else if (s.ram)
            next_s.rdata = ram_rdata;
          else
            next_s.rdata = io_rdata;
        end
      end
      DEV_HOLD:
      begin
        if (!(mem_rd || mem_wr || io_rd || io_wr))
        begin
          next_s.st = DEV_IDLE;
          next_s.d_oe = 1'b0;
          next_s.inpack = 1'b0;
          next_s.iois16 = 1'b0;
        end
      end
      default:
        next_s = dev_reset();
    endcase
    if (link.card_reset)
      next_s = dev_reset();
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s <= dev_reset();
    else
      s <= next_s;
  end

  assign link.card_d = s.rdata;
  assign link.card_d_oe = s.d_oe;
  assign link.wait_val_n = s.wait_n;
  // Slave mode keeps these lines open drain
  assign link.wait_oe = card_mode_strap || !s.wait_n;
  assign link.iois16_val_n = !s.iois16;
  assign link.iois16_oe = card_mode_strap || s.iois16;
  assign link.inpack_n = !s.inpack;
  assign link.ireq_n = !s.ireq;
  assign link.stschg_n = !s.stschg;
  assign core_sleep = s.sleep;
  assign ext_addr = s.addr;
  assign ext_wdata = s.wdata;
  assign ext_rd = s.rd_en;
  assign ext_wr = s.wr_en;
  assign flash_sel = s.flash;
  assign local_ram_select = s.ram;
  assign io_access = s.io;
  assign io_sel = s.addr[IO_SEL_BITS-1:0];
endmodule : pcs_card_device

// [test/pcs_card_chk.sv]
`timescale 1ns/100ps
module pcs_card_chk
  import pcs_pkg::*;
(
  input logic aclk,
  input logic aresetn,
  input logic [15:0] addr,
  input logic [15:0] d,
  input logic ce1_n,
  input logic ce2_n,
  input logic reg_n,
  input logic oe_n,
  input logic we_n,
  input logic iord_n,
  input logic iowr_n,
  input logic card_reset,
  input logic card_d_oe,
  input logic wait_n,
  input logic wait_oe,
  input logic inpack_n
);
  logic [7:0] wait_cnt;
  logic io_en;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Pin-side shadow of the I/O enable bit
  always_ff @(posedge aclk)
  begin
    if (!aresetn || wait_n)
      wait_cnt <= 8'h00;
    else
      wait_cnt <= wait_cnt + 8'h01;
    if (!aresetn || card_reset)
      io_en <= 1'b0;
    else if (!we_n && !ce1_n && !reg_n && addr == CFG_OPTION_OFFSET)
      io_en <= d[0];
  end

  sequence cfg_read_s;
    !ce1_n && !reg_n && addr[15:3] == 13'h007E && !addr[0] && $fell(oe_n);
  endsequence
  sequence answer_s;
    card_d_oe && wait_n;
  endsequence
  sequence wait_end_s;
    $rose(wait_n) && !card_reset;
  endsequence

  cfg_no_wait_a: assert property (cfg_read_s |=> answer_s)
    else $error("config read not answered at once");
  wait_drive_a: assert property (wait_end_s |-> wait_oe)
    else $error("wait released instead of driven high");
  wait_length_a: assert property (
    wait_end_s |-> wait_cnt == EXT_CYCLES)
    else $error("wait low for wrong count");
  io_gate_a: assert property (
    !iord_n && !io_en |-> !card_d_oe && inpack_n)
    else $error("io answered while disabled");
  odd_attr_a: assert property (
    !ce1_n && !reg_n && addr[0] && !(oe_n && we_n)
    |-> !card_d_oe && wait_n)
    else $error("odd attribute address answered");
  release_a: assert property ($rose(oe_n) && iord_n |=> !card_d_oe)
    else $error("data bus not released");
  inpack_a: assert property (
    !inpack_n |-> !iord_n || !$past(iord_n))
    else $error("inpack outside io read");
  wait_strobe_a: assert property ($fell(wait_n)
    |-> !(oe_n && we_n && iord_n && iowr_n) && !(ce1_n && ce2_n))
    else $error("wait without a strobe");
  card_reset_a: assert property (
    card_reset |=> wait_n && !card_d_oe)
    else $error("card reset did not idle the card");
endmodule : pcs_card_chk

// [test/pcs_card_slave_interface_tb.sv]
`timescale 1ns/100ps
module pcs_card_slave_interface_tb;
  import pcs_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, r, st;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic bready = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rs;
  logic strap = 1'b1, match = 1'b1, sleep_n = 1'b1;
  logic [15:0] misc = 16'h0000, io_rdata = 16'h0000;
  logic core_sleep, ext_rd, ext_wr, flash_sel, ram_sel, io_access;
  logic [15:0] ext_addr, ext_wdata;
  logic [4:0] io_sel;
  logic [5:0] cfg_index;
  logic irq = 1'b0;
  logic [15:0] wr_seen, io_seen;
  int fail_count = 0;
  int samples_checked = 0;
  int n_fl = 0, n_ram = 0, n_wr = 0, n_io = 0, s_fl, s_ram, s_wr, s_io;

  pcs_card_if lnk ();
  pcs_card_device i_pcs_card_device (
    .aclk(aclk), .aresetn(aresetn), .link(lnk),
    .card_mode_strap(strap), .shared_mem_match(match), .sleep_n(sleep_n),
    .misc_config_reg_two(misc), .core_irq(irq),
    .core_status_change(1'b0), .core_sleep(core_sleep),
    .ext_addr(ext_addr), .ext_wdata(ext_wdata), .ext_rd(ext_rd),
    .ext_wr(ext_wr), .flash_sel(flash_sel), .local_ram_select(ram_sel),
    .io_access(io_access), .io_sel(io_sel), .flash_rdata(8'hA5),
    .ram_rdata(16'h1234), .io_rdata(io_rdata), .config_index(cfg_index));
  pcs_card_host i_pcs_card_host (
    .aclk(aclk), .aresetn(aresetn), .link(lnk),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  pcs_card_chk i_pcs_card_chk (
    .aclk(aclk), .aresetn(aresetn), .addr(lnk.addr), .d(lnk.d),
    .ce1_n(lnk.ce1_n), .ce2_n(lnk.ce2_n), .reg_n(lnk.reg_n),
    .oe_n(lnk.oe_n), .we_n(lnk.we_n), .iord_n(lnk.iord_n),
    .iowr_n(lnk.iowr_n), .card_reset(lnk.card_reset),
    .card_d_oe(lnk.card_d_oe), .wait_n(lnk.wait_n),
    .wait_oe(lnk.wait_oe), .inpack_n(lnk.inpack_n));

  initial
  begin
    forever #2 aclk = ~aclk;
  end

  // Cycle counts of each external strobe kind
  always @(posedge aclk)
  begin
    n_fl += ext_rd && flash_sel;
    n_ram += ram_sel;
    n_wr += ext_wr;
    n_io += io_access;
    // Strobe-time values; the idle device tracks the pins afterwards
    if (ext_wr)
      wr_seen = ext_wdata;
    if (io_access)
      io_seen = ext_addr;
  end

  task automatic summarize;
    $display("checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic snap;
    s_fl = n_fl;
    s_ram = n_ram;
    s_wr = n_wr;
    s_io = n_io;
  endtask : snap

  task automatic axi(input logic wr, input logic [7:0] a,
    input logic [31:0] v);
    logic ha, hw, hb;
    int n;
    @(posedge aclk);
    awaddr <= a;
    araddr <= a;
    wdata <= v;
    awvalid <= wr;
    wvalid <= wr;
    bready <= wr;
    arvalid <= !wr;
    rready <= !wr;
    hb = 1'b0;
    for (n = 0; n < 100 && !hb; n++)
    begin
      #1;
      ha = (awvalid && awready) || (arvalid && arready);
      hw = wvalid && wready;
      hb = (bvalid && bready) || (rvalid && rready);
      r = rdata;
      rs = wr ? bresp : rresp;
      @(posedge aclk);
      awvalid <= awvalid && !ha;
      arvalid <= arvalid && !ha;
      wvalid <= wvalid && !hw;
      bready <= bready && !hb;
      rready <= rready && !hb;
    end
    if (!hb)
      summarize_on_hang();
  endtask : axi

  task automatic summarize_on_hang;
    fail_count++;
    summarize();
  endtask : summarize_on_hang

  task automatic op(input logic [2:0] cmd, input logic [15:0] a,
    input logic [15:0] w);
    int n;
    axi(1'b1, HOST_STATUS_OFFSET, 32'h6);
    axi(1'b1, HOST_ADDR_OFFSET, {16'h0, a});
    axi(1'b1, HOST_WDATA_OFFSET, {16'h0, w});
    axi(1'b1, HOST_CMD_OFFSET, {29'h0, cmd});
    st = 32'h0;
    for (n = 0; n < 300 && !(st[ST_DONE_BIT] || st[ST_MISS_BIT]); n++)
    begin
      axi(1'b0, HOST_STATUS_OFFSET, 32'h0);
      st = r;
    end
    if (!(st[ST_DONE_BIT] || st[ST_MISS_BIT]))
      summarize_on_hang();
    axi(1'b0, HOST_RDATA_OFFSET, 32'h0);
  endtask : op

  task automatic t_regs;
    int i;
    axi(1'b0, 8'h40, 32'h0);
    chk({14'h0, rs}, {14'h0, AXI_SLVERR});
    for (i = 0; i < 4; i++)
    begin
      op({1'b1, OP_MEM_RD}, CFG_OPTION_OFFSET + 16'(2 * i), 16'h0);
      chk({8'h00, r[7:0]}, {8'h00, CFG_RESET});
    end
    io_rdata <= 16'hC35A;
    axi(1'b1, HOST_WINDOW_OFFSET, 32'h0300);
    snap();
    op({1'b0, OP_IO_RD}, 16'h0333, 16'h0);
    chk(16'(n_io - s_io), 16'h0);
    chk(r[15:0], 16'h0000);
    $display("done regs");
  endtask : t_regs

  task automatic t_cfg;
    int i;
    op({1'b1, OP_MEM_WR}, CFG_OPTION_OFFSET, 16'h0021);
    op({1'b1, OP_MEM_RD}, CFG_OPTION_OFFSET, 16'h0);
    chk({8'h00, r[7:0]}, 16'h0021);
    chk({10'h0, cfg_index}, 16'h0021);
    for (i = 1; i < 4; i++)
    begin
      op({1'b1, OP_MEM_WR}, CFG_OPTION_OFFSET + 16'(2 * i),
        16'(16'h0040 + i));
      op({1'b1, OP_MEM_RD}, CFG_OPTION_OFFSET + 16'(2 * i), 16'h0);
      chk({8'h00, r[7:0]}, 16'(16'h0040 + i));
    end
    snap();
    op({1'b1, OP_MEM_RD}, 16'h0001, 16'h0);
    chk(16'(n_fl - s_fl), 16'h0);
    snap();
    op({1'b0, OP_IO_RD}, 16'h0333, 16'h0);
    chk(r[15:0], 16'hC35A);
    chk({11'h0, io_sel}, 16'h0013);
    chk(io_seen, 16'h0013);
    chk(16'(n_io - s_io), 16'(EXT_CYCLES));
    irq <= 1'b1;
    repeat (2) @(posedge aclk);
    chk({15'h0, lnk.ireq_n}, 16'h0000);
    irq <= 1'b0;
    snap();
    op({1'b0, OP_IO_RD}, 16'h0733, 16'h0);
    chk({15'h0, st[ST_MISS_BIT]}, 16'h0001);
    chk(16'(n_io - s_io), 16'h0);
    $display("done cfg");
  endtask : t_cfg

  task automatic t_mem;
    snap();
    op({1'b1, OP_MEM_RD}, 16'h0000, 16'h0);
    chk({8'h00, r[7:0]}, 16'h00A5);
    chk(ext_addr, 16'h0000);
    chk(16'(n_fl - s_fl), 16'(EXT_CYCLES));
    snap();
    op({1'b0, OP_MEM_RD}, 16'h8000, 16'h0);
    chk(16'(n_fl - s_fl), 16'(EXT_CYCLES));
    chk({8'h00, r[7:0]}, 16'h00A5);
    match <= 1'b0;
    snap();
    op({1'b0, OP_MEM_RD}, 16'h0100, 16'h0);
    chk(16'(n_ram - s_ram), 16'(EXT_CYCLES));
    chk(r[15:0], 16'h1234);
    misc <= 16'h2000;
    snap();
    op({1'b0, OP_MEM_RD}, 16'h0100, 16'h0);
    chk(16'(n_ram - s_ram), 16'h0);
    match <= 1'b1;
    op({1'b0, OP_MEM_RD}, 16'h0000, 16'h0);
    chk({8'h00, r[7:0]}, 16'h00A5);
    misc <= 16'h0000;
    snap();
    op({1'b0, OP_MEM_WR}, 16'h8002, 16'h005A);
    chk(16'(n_wr - s_wr), 16'h0);
    misc <= 16'h0100;
    snap();
    op({1'b0, OP_MEM_WR}, 16'h8002, 16'h005A);
    chk(16'(n_wr - s_wr), 16'(EXT_CYCLES));
    chk({8'h00, wr_seen[7:0]}, 16'h005A);
    $display("done mem");
  endtask : t_mem

  task automatic t_misc;
    strap <= 1'b0;
    snap();
    op({1'b1, OP_MEM_RD}, 16'h0000, 16'h0);
    chk(16'(n_fl - s_fl), 16'h0);
    chk({8'h00, r[7:0]}, 16'h0000);
    strap <= 1'b1;
    sleep_n <= 1'b0;
    repeat (3) @(posedge aclk);
    chk({15'h0, core_sleep}, 16'h0001);
    sleep_n <= 1'b1;
    axi(1'b1, HOST_CTRL_OFFSET, 32'h1);
    axi(1'b1, HOST_CTRL_OFFSET, 32'h0);
    op({1'b1, OP_MEM_RD}, CFG_OPTION_OFFSET, 16'h0);
    chk({8'h00, r[7:0]}, 16'h0000);
    snap();
    op({1'b0, OP_IO_RD}, 16'h0333, 16'h0);
    chk(16'(n_io - s_io), 16'h0);
    $display("done misc");
  endtask : t_misc

  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_cfg();
    t_mem();
    t_misc();
    summarize();
  end
endmodule : pcs_card_slave_interface_tb
